// File: common/bcht_params.svh
// offsets, field positions, reset values and decode constants of the header tail
`ifndef BCHT_PARAMS_SVH
`define BCHT_PARAMS_SVH

// byte offsets inside the configuration header
`define BCHT_OFS_CAP_PTR 12'h034
`define BCHT_OFS_ROM_BASE 12'h038
`define BCHT_OFS_IRQ_CTRL 12'h03c

// fixed read values and the interrupt line reset value
`define BCHT_CAP_PTR_VAL 8'h80
`define BCHT_ROM_BASE_VAL 32'h0000_0000
`define BCHT_IRQ_PIN_VAL 8'h01
`define BCHT_IRQ_LINE_RST 8'h00

// bridge control field positions in the 0x3c word
`define BCHT_BIT_PERR_RESP 16
`define BCHT_BIT_SERR_EN 17
`define BCHT_BIT_ISA_EN 18
`define BCHT_BIT_VGA_EN 19
`define BCHT_BIT_VGA16 20
`define BCHT_CTRL_RST 5'h00

// vga compatible ranges
`define BCHT_VGA_MEM_LO 32'h000a_0000
`define BCHT_VGA_MEM_HI 32'h000b_ffff
`define BCHT_VGA_IO_A_LO 10'h3b0
`define BCHT_VGA_IO_A_HI 10'h3bb
`define BCHT_VGA_IO_B_LO 10'h3c0
`define BCHT_VGA_IO_B_HI 10'h3df

`endif

// File: common/bcht_pkg.sv
// types shared by the header tail register bank and its forwarding decoder
package bcht_pkg;

  // bridge control bits 20:16, lsb is bit 16
  typedef struct packed {
    logic vga16;      // 16-bit vga i/o decode
    logic vga_en;     // vga forwarding
    logic isa_en;     // isa alias filtering
    logic serr_en;    // secondary serr forwarding
    logic perr_resp;  // secondary parity response
  } bcht_ctrl_t;

  // one forwarding lookup
  typedef struct packed {
    logic is_io;         // i/o space, else memory
    logic [31:0] addr;   // transaction address
    logic io_win_hit;    // inside programmed i/o window
    logic mem_win_hit;   // inside programmed memory windows
  } bcht_fwd_req_t;

  // apb slave phase, one-hot
  typedef enum logic [1:0] {
    BCHT_ST_IDLE = 2'b01,
    BCHT_ST_ACCESS = 2'b10
  } bcht_apb_st_t;

endpackage : bcht_pkg

// File: core/bcht_fwd_decode.sv
// primary to secondary forwarding decision steered by bridge control bits
`timescale 1ns/1ps
`default_nettype none
`include "bcht_params.svh"

module bcht_fwd_decode
  import bcht_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire bcht_fwd_req_t req_in,
  input wire bcht_ctrl_t ctrl_in,
  input wire logic io_enable_in,
  input wire logic mem_enable_in,
  output logic valid_out,
  output logic fwd_down_out,
  output logic fwd_up_out
);

  // vga i/o test; the short decode ignores bits 15:10 so aliases also match
  function automatic logic is_vga_io(input logic [31:0] a, input logic full16);
    logic in_rng;
    in_rng = ((a[9:0] >= `BCHT_VGA_IO_A_LO) && (a[9:0] <= `BCHT_VGA_IO_A_HI)) ||
             ((a[9:0] >= `BCHT_VGA_IO_B_LO) && (a[9:0] <= `BCHT_VGA_IO_B_HI));
    is_vga_io = in_rng && (a[31:16] == 16'h0000) && (!full16 || (a[15:10] == 6'h00));
  endfunction : is_vga_io

  logic valid_q;     // lookup result valid
  logic down_q;      // claimed for the secondary
  logic next_valid;
  logic next_down;
  logic isa_alias;   // first 64kb, top 768 bytes of a 1kb block
  logic vga_mem;     // inside vga frame buffer range
  logic io_down;
  logic mem_down;

  // next decision; vga forwarding overrides the isa filter
  always_comb
  begin
    isa_alias = (req_in.addr[31:16] == 16'h0000) && (req_in.addr[9:8] != 2'b00);
    vga_mem = (req_in.addr >= `BCHT_VGA_MEM_LO) && (req_in.addr <= `BCHT_VGA_MEM_HI);
    // isa set: aliased addresses stay upstream
    io_down = io_enable_in &&
              ((req_in.io_win_hit && !(ctrl_in.isa_en && isa_alias)) ||
               (ctrl_in.vga_en && is_vga_io(req_in.addr, ctrl_in.vga16)));
    mem_down = mem_enable_in && (req_in.mem_win_hit || (ctrl_in.vga_en && vga_mem));
    next_valid = req_valid_in;
    next_down = req_valid_in && (req_in.is_io ? io_down : mem_down);
  end

  // result registered one cycle after the lookup
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      valid_q <= 1'b0;
      down_q <= 1'b0;
    end
    else
    begin
      valid_q <= next_valid;
      down_q <= next_down;
    end
  end

  assign valid_out = valid_q;
  assign fwd_down_out = down_q;
  assign fwd_up_out = valid_q && !down_q;

endmodule : bcht_fwd_decode
`default_nettype wire

// File: core/bcht_cfg_tail.sv
// apb register bank for the type-1 header tail with error steering and forwarding decode
// Operation
// - rom base reads zero, writes ignored
// - interrupt line byte read-write, resets zero
// - interrupt pin byte reads constant one
// - parity response bit resets zero, enables detection
// - forward mode: gates secondary error response
// - reverse mode: gates poisoned tlp parity status
// - forward mode: serr forwarded as error message
// - reverse mode: serr enable bit read-only
// - isa clear: forward whole i/o window
// - isa set: aliased low addresses stay upstream
// - vga clear: vga only through windows
// - vga set: forward vga when enables set
// - vga16 bit selects 10 or 16-bit decode
// - capability pointer reads 80h, read-only
`timescale 1ns/1ps
`default_nettype none
`include "bcht_params.svh"

module bcht_cfg_tail
  import bcht_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  // mode strap and secondary error sources
  input wire logic reverse_mode_in,
  input wire logic sec_serr_n_in,
  input wire logic sec_bus_err_in,
  input wire logic poisoned_tlp_in,
  output logic sec_err_resp_out,
  output logic mdpe_set_out,
  output logic err_msg_req_out,
  // forwarding lookup
  input wire logic fwd_valid_in,
  input wire bcht_fwd_req_t fwd_req_in,
  input wire logic io_enable_in,
  input wire logic mem_enable_in,
  output logic fwd_valid_out,
  output logic fwd_down_out,
  output logic fwd_up_out,
  // register state for the rest of the bridge
  output bcht_ctrl_t ctrl_out,
  output logic [7:0] irq_line_out
);

  // apb phase tracking
  bcht_apb_st_t st_q;
  bcht_apb_st_t next_st;

  // register contents
  logic [7:0] irq_line_q;     // software scratch, steers nothing
  bcht_ctrl_t ctrl_q;         // bridge control bits 20:16
  logic [7:0] next_irq_line;
  bcht_ctrl_t next_ctrl;

  // read path, loaded in the setup cycle so it is stable in access
  logic [31:0] rdata_q;
  logic err_q;
  logic [31:0] next_rdata;
  logic next_err;

  // pin synchronisers: stage one feeds stage two only
  logic rev_s1;
  logic rev_s2;
  logic serr_s1;
  logic serr_s2;
  logic serr_d;               // delayed stage two for edge detect
  logic next_rev_s1;
  logic next_rev_s2;
  logic next_serr_s1;
  logic next_serr_s2;
  logic next_serr_d;

  // error event pulses
  logic sec_err_resp_q;
  logic mdpe_set_q;
  logic err_msg_req_q;
  logic next_sec_err_resp;
  logic next_mdpe_set;
  logic next_err_msg_req;

  // bus qualifiers
  logic setup_cyc;            // first cycle of a transfer
  logic wr_fire;              // write commits at this edge
  logic [ADDR_W-1:0] word_addr;

  // offset known to this bank
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == ADDR_W'(`BCHT_OFS_CAP_PTR)) ||
                (a == ADDR_W'(`BCHT_OFS_ROM_BASE)) ||
                (a == ADDR_W'(`BCHT_OFS_IRQ_CTRL));
  endfunction : is_mapped

  // read mux; reserved bits 31:21 of the control word read zero
  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a,
                                            input logic [7:0] line,
                                            input bcht_ctrl_t c,
                                            input logic rev);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == ADDR_W'(`BCHT_OFS_CAP_PTR))
    begin
      w[7:0] = `BCHT_CAP_PTR_VAL;
    end
    else if (a == ADDR_W'(`BCHT_OFS_ROM_BASE))
    begin
      w = `BCHT_ROM_BASE_VAL;
    end
    else if (a == ADDR_W'(`BCHT_OFS_IRQ_CTRL))
    begin
      w[7:0] = line;
      w[15:8] = `BCHT_IRQ_PIN_VAL;
      w[`BCHT_BIT_PERR_RESP] = c.perr_resp;
      // in reverse mode the serr enable reads as a fixed zero
      w[`BCHT_BIT_SERR_EN] = c.serr_en && !rev;
      w[`BCHT_BIT_ISA_EN] = c.isa_en;
      w[`BCHT_BIT_VGA_EN] = c.vga_en;
      w[`BCHT_BIT_VGA16] = c.vga16;
    end
    read_word = w;
  endfunction : read_word

  // aligned word address; byte lanes come from pstrb
  assign word_addr = {paddr_in[ADDR_W-1:2], 2'b00};
  assign setup_cyc = psel_in && !penable_in;
  // zero wait state slave: access cycle always completes
  assign wr_fire = psel_in && penable_in && pwrite_in && (st_q == BCHT_ST_ACCESS);

  // apb phase next state
  always_comb
  begin
    case (st_q)
      BCHT_ST_IDLE:
      begin
        // wait for a setup cycle
        next_st = setup_cyc ? BCHT_ST_ACCESS : BCHT_ST_IDLE;
      end
      BCHT_ST_ACCESS:
      begin
        // access always ends here; a following setup is seen from idle
        next_st = BCHT_ST_IDLE;
      end
      default:
      begin
        next_st = BCHT_ST_IDLE;
      end
    endcase
  end

  // apb phase register
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_q <= BCHT_ST_IDLE;
    end
    else
    begin
      st_q <= next_st;
    end
  end

  // register next values; writes to read-only fields simply drop
  always_comb
  begin
    next_irq_line = irq_line_q;
    next_ctrl = ctrl_q;
    if (wr_fire && (word_addr == ADDR_W'(`BCHT_OFS_IRQ_CTRL)))
    begin
      if (pstrb_in[0])
      begin
        next_irq_line = pwdata_in[7:0];
      end
      // byte 1 holds the pin code, not writable
      if (pstrb_in[2])
      begin
        next_ctrl.perr_resp = pwdata_in[`BCHT_BIT_PERR_RESP];
        // reverse bridge keeps the serr enable frozen
        if (!rev_s2)
        begin
          next_ctrl.serr_en = pwdata_in[`BCHT_BIT_SERR_EN];
        end
        next_ctrl.isa_en = pwdata_in[`BCHT_BIT_ISA_EN];
        next_ctrl.vga_en = pwdata_in[`BCHT_BIT_VGA_EN];
        next_ctrl.vga16 = pwdata_in[`BCHT_BIT_VGA16];
      end
    end
  end

  // register storage, all control bits clear at reset
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      irq_line_q <= `BCHT_IRQ_LINE_RST;
      ctrl_q <= `BCHT_CTRL_RST;
    end
    else
    begin
      irq_line_q <= next_irq_line;
      ctrl_q <= next_ctrl;
    end
  end

  // read data and error, captured in setup so access needs no wait
  always_comb
  begin
    next_rdata = rdata_q;
    next_err = err_q;
    if (setup_cyc)
    begin
      next_rdata = pwrite_in ? 32'h0000_0000 : read_word(word_addr, irq_line_q, ctrl_q, rev_s2);
      // unmapped offsets answer with an error, reads give zero
      next_err = !is_mapped(word_addr);
    end
    else if (st_q == BCHT_ST_ACCESS)
    begin
      next_err = 1'b0;
    end
  end

  // read path registers
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end
    else
    begin
      rdata_q <= next_rdata;
      err_q <= next_err;
    end
  end

  // synchroniser next values; a mid-run mode change is tolerated but not meant
  always_comb
  begin
    next_rev_s1 = reverse_mode_in;
    next_rev_s2 = rev_s1;
    next_serr_s1 = sec_serr_n_in;
    next_serr_s2 = serr_s1;
    next_serr_d = serr_s2;
  end

  // synchroniser registers; serr idles high
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rev_s1 <= 1'b0;
      rev_s2 <= 1'b0;
      serr_s1 <= 1'b1;
      serr_s2 <= 1'b1;
      serr_d <= 1'b1;
    end
    else
    begin
      rev_s1 <= next_rev_s1;
      rev_s2 <= next_rev_s2;
      serr_s1 <= next_serr_s1;
      serr_s2 <= next_serr_s2;
      serr_d <= next_serr_d;
    end
  end

  // error steering; serr gives one pulse per falling edge, the other two follow their strobe each cycle, mode picks which source counts
  always_comb
  begin
    next_sec_err_resp = !rev_s2 && ctrl_q.perr_resp && sec_bus_err_in;
    next_mdpe_set = rev_s2 && ctrl_q.perr_resp && poisoned_tlp_in;
    // falling edge of the active-low pin, seen after the two stages
    next_err_msg_req = !rev_s2 && ctrl_q.serr_en && serr_d && !serr_s2;
  end

  // error pulse registers
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sec_err_resp_q <= 1'b0;
      mdpe_set_q <= 1'b0;
      err_msg_req_q <= 1'b0;
    end
    else
    begin
      sec_err_resp_q <= next_sec_err_resp;
      mdpe_set_q <= next_mdpe_set;
      err_msg_req_q <= next_err_msg_req;
    end
  end

  // forwarding decoder steered by the control bits
  bcht_fwd_decode u_fwd_decode (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .req_valid_in(fwd_valid_in),
    .req_in(fwd_req_in),
    .ctrl_in(ctrl_q),
    .io_enable_in(io_enable_in),
    .mem_enable_in(mem_enable_in),
    .valid_out(fwd_valid_out),
    .fwd_down_out(fwd_down_out),
    .fwd_up_out(fwd_up_out)
  );

  // outputs
  assign pready_out = 1'b1;
  assign prdata_out = rdata_q;
  assign pslverr_out = err_q && (st_q == BCHT_ST_ACCESS);
  assign sec_err_resp_out = sec_err_resp_q;
  assign mdpe_set_out = mdpe_set_q;
  assign err_msg_req_out = err_msg_req_q;
  assign ctrl_out = ctrl_q;
  assign irq_line_out = irq_line_q;

endmodule : bcht_cfg_tail
`default_nettype wire

// File: tb/bcht_sec_model.sv
// secondary side model: serr pin on a pull-up plus error and poison strobes
`timescale 1ns/1ps
`default_nettype none
module bcht_sec_model
(
  input wire logic clk_in,
  output logic serr_n_out,
  output logic berr_out,
  output logic poison_out
);
  // idle levels from time zero; serr rests on its pull-up
  initial
  begin
    serr_n_out = 1'b1;
    berr_out = 1'b0;
    poison_out = 1'b0;
  end
  // pull serr low for n edges, then let the pull-up take it back
  task automatic serr_low(input int n);
    @(posedge clk_in);
    serr_n_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    serr_n_out <= 1'b1;
  endtask : serr_low
  // one-cycle strobe: p set gives a poisoned tlp, else a bus error
  task automatic strobe(input logic p);
    @(posedge clk_in);
    poison_out <= p;
    berr_out <= !p;
    @(posedge clk_in);
    poison_out <= 1'b0;
    berr_out <= 1'b0;
  endtask : strobe
endmodule : bcht_sec_model
`default_nettype wire

// File: tb/bcht_cfg_tail_monitor.sv
// concurrent checks on the header tail register bank ports
`timescale 1ns/1ps
`default_nettype none
module bcht_cfg_tail_monitor
  import bcht_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic sec_bus_err_in,
  input wire logic poisoned_tlp_in,
  input wire logic sec_err_resp_out,
  input wire logic mdpe_set_out,
  input wire logic err_msg_req_out,
  input wire logic fwd_valid_in,
  input wire logic fwd_valid_out,
  input wire logic fwd_down_out,
  input wire logic fwd_up_out,
  input wire bcht_ctrl_t ctrl_out,
  input wire logic [7:0] irq_line_out
);
  default clocking mon_cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  // access-phase decodes; reads only look at settled read data
  wire logic at38 = psel_in & penable_in & (paddr_in == ADDR_W'(12'h038));
  wire logic at3c = psel_in & penable_in & (paddr_in == ADDR_W'(12'h03c));
  a_rom_reads_zero: assert property (at38 && !pwrite_in |-> prdata_out == 32'h0)
    else $error("rom base read not zero");
  a_pin_and_line: assert property (at3c && !pwrite_in |-> prdata_out[15:0] == {8'h01, irq_line_out})
    else $error("pin or line byte read wrong");
  a_ctrl_readback: assert property (at3c && !pwrite_in |-> {prdata_out[20:18], prdata_out[16]} ==
    {ctrl_out.vga16, ctrl_out.vga_en, ctrl_out.isa_en, ctrl_out.perr_resp})
    else $error("control bits read wrong");
  a_line_write: assert property (at3c && pwrite_in && pstrb_in[0] |=> irq_line_out == $past(pwdata_in[7:0]))
    else $error("line byte not stored");
  a_ctrl_write: assert property (at3c && pwrite_in && pstrb_in[2] |=>
    {ctrl_out.vga16, ctrl_out.vga_en, ctrl_out.isa_en} == $past(pwdata_in[20:18]))
    else $error("control bits not stored");
  a_perr_gate: assert property (sec_err_resp_out |-> $past(sec_bus_err_in) && $past(ctrl_out.perr_resp))
    else $error("error response without enable");
  a_mdpe_gate: assert property (mdpe_set_out |-> $past(poisoned_tlp_in) && $past(ctrl_out.perr_resp))
    else $error("parity status without enable");
  a_serr_pulse: assert property (err_msg_req_out |-> $past(ctrl_out.serr_en) ##1 !err_msg_req_out)
    else $error("error message bad");
  a_fwd_answer: assert property (fwd_valid_in |=> fwd_valid_out && (fwd_up_out != fwd_down_out))
    else $error("forward answer bad");
  a_ctrl_reset: assert property ($fell(rst_in) |-> ctrl_out == '0 && irq_line_out == 8'h00)
    else $error("reset values wrong");
  // main scenarios reached
  c_ctrl_write: cover property (at3c && pwrite_in);
  c_err_msg: cover property (err_msg_req_out);
  c_fwd_down: cover property (fwd_valid_out && fwd_down_out);
endmodule : bcht_cfg_tail_monitor
bind bcht_cfg_tail bcht_cfg_tail_monitor #(.ADDR_W(ADDR_W)) u_mon (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
  .prdata_out(prdata_out), .sec_bus_err_in(sec_bus_err_in), .poisoned_tlp_in(poisoned_tlp_in),
  .sec_err_resp_out(sec_err_resp_out), .mdpe_set_out(mdpe_set_out), .err_msg_req_out(err_msg_req_out),
  .fwd_valid_in(fwd_valid_in), .fwd_valid_out(fwd_valid_out), .fwd_down_out(fwd_down_out),
  .fwd_up_out(fwd_up_out), .ctrl_out(ctrl_out), .irq_line_out(irq_line_out)
);
`default_nettype wire

// File: tb/bridge_cfg_header_tail_tb.sv
// self-checking bench for the header tail register bank
`timescale 1ns/1ps
`default_nettype none
module bridge_cfg_header_tail_tb;
  import bcht_pkg::*;
  // design inputs; idle levels are set at time zero by the stimulus process
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel, pen, pwr, rev;
  logic fvi, ioen, memen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  bcht_fwd_req_t freq;
  // register state seen by the rest of the bridge
  bcht_ctrl_t ctrl;
  logic [7:0] irq_line;
  // design and model outputs
  logic pready, pslverr, serr_n, berr, poison, eresp, mdpe, msg, fv, fd, fu, er;
  int num_errors = 0;
  int n_tests = 0;
  int n_msg = 0;
  // 200 mhz core clock
  always #2.5 clk = ~clk;
  // count upstream error message requests
  always @(posedge clk)
  begin
    if (msg === 1'b1)
      n_msg <= n_msg + 1;
  end
  bcht_sec_model sec (.clk_in(clk), .serr_n_out(serr_n), .berr_out(berr), .poison_out(poison));
  bcht_cfg_tail #(.ADDR_W(12)) uut (
    .ref_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .pready_out(pready), .prdata_out(prdata),
    .pslverr_out(pslverr), .reverse_mode_in(rev), .sec_serr_n_in(serr_n), .sec_bus_err_in(berr),
    .poisoned_tlp_in(poison), .sec_err_resp_out(eresp), .mdpe_set_out(mdpe), .err_msg_req_out(msg),
    .fwd_valid_in(fvi), .fwd_req_in(freq), .io_enable_in(ioen), .mem_enable_in(memen),
    .fwd_valid_out(fv), .fwd_down_out(fd), .fwd_up_out(fu), .ctrl_out(ctrl), .irq_line_out(irq_line)
  );
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one apb transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk("prdata", rd, exp);
  endtask : rdc
  // ctrl bits, flags {is_io, window hit, enable, forwarded down}, address
  task automatic fc(input logic [4:0] c, input logic [3:0] f, input logic [31:0] a);
    apb(1'b1, 12'h03c, {11'h0, c, 16'h0}, 4'h4);
    @(posedge clk);
    fvi <= 1'b1;
    freq <= '{is_io: f[3], addr: a, io_win_hit: f[3] & f[2], mem_win_hit: !f[3] & f[2]};
    ioen <= f[1];
    memen <= f[1];
    @(posedge clk);
    fvi <= 1'b0;
    @(negedge clk);
    chk("fwd", {29'h0, fv, fd, fu}, {29'h0, 1'b1, f[0], !f[0]});
  endtask : fc
  task automatic tally_and_finish();
    if (num_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // watchdog far beyond the couple of hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
  initial
  begin
    // idle bus, forward strap, no lookup pending
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    rev = 1'b0;
    fvi = 1'b0;
    ioen = 1'b0;
    memen = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    freq = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rdc(12'h034, 32'h0000_0080);
    rdc(12'h03c, 32'h0000_0100);
    apb(1'b1, 12'h038, 32'hffff_ffff, 4'hf);
    rdc(12'h038, 32'h0);
    apb(1'b1, 12'h034, 32'hffff_ffff, 4'hf);
    rdc(12'h034, 32'h0000_0080);
    apb(1'b1, 12'h03c, 32'hffff_ffa5, 4'hf);
    rdc(12'h03c, 32'h001f_01a5);
    chk("ctrl_out", {27'h0, ctrl}, 32'h0000_001f);
    chk("irq_line_out", {24'h0, irq_line}, 32'h0000_00a5);
    apb(1'b1, 12'h03c, 32'h0000_005a, 4'h1);
    rdc(12'h03c, 32'h001f_015a);
    apb(1'b0, 12'h040, 32'h0, 4'h0);
    chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
    // error steering with every enable clear, then parity response and serr enable set
    apb(1'b1, 12'h03c, 32'h0, 4'h4);
    sec.strobe(1'b0);
    @(negedge clk);
    chk("err_resp", {31'h0, eresp}, 32'h0);
    sec.serr_low(4);
    repeat (6) @(posedge clk);
    chk("msgs", 32'(n_msg), 32'h0);
    apb(1'b1, 12'h03c, 32'h0003_0000, 4'h4);
    sec.strobe(1'b0);
    @(negedge clk);
    chk("err_resp", {31'h0, eresp}, 32'h1);
    sec.strobe(1'b1);
    @(negedge clk);
    chk("mdpe", {31'h0, mdpe}, 32'h0);
    sec.serr_low(4);
    repeat (6) @(posedge clk);
    chk("msgs", 32'(n_msg), 32'h1);
    // reverse bridge: poison steering, serr enable frozen
    rev <= 1'b1;
    repeat (3) @(posedge clk);
    sec.strobe(1'b1);
    @(negedge clk);
    chk("mdpe", {31'h0, mdpe}, 32'h1);
    sec.strobe(1'b0);
    @(negedge clk);
    chk("err_resp", {31'h0, eresp}, 32'h0);
    rdc(12'h03c, 32'h0001_015a);
    apb(1'b1, 12'h03c, 32'h0, 4'h4);
    @(posedge clk);
    rev <= 1'b0;
    repeat (3) @(posedge clk);
    rdc(12'h03c, 32'h0002_015a);
    // forwarding decisions
    fc(5'h00, 4'b1111, 32'h0000_0100);
    fc(5'h00, 4'b1010, 32'h0000_03c0);
    fc(5'h00, 4'b0010, 32'h000a_0000);
    fc(5'h04, 4'b1110, 32'h0000_0100);
    fc(5'h04, 4'b1111, 32'h0000_0400);
    fc(5'h04, 4'b1111, 32'h0001_0100);
    fc(5'h0c, 4'b1011, 32'h0000_03c0);
    fc(5'h0c, 4'b0011, 32'h000b_fff0);
    fc(5'h08, 4'b0000, 32'h000a_0000);
    fc(5'h08, 4'b1011, 32'h0000_13c0);
    fc(5'h18, 4'b1010, 32'h0000_13c0);
    fc(5'h18, 4'b1011, 32'h0000_03b0);
    tally_and_finish();
  end
endmodule : bridge_cfg_header_tail_tb
`default_nettype wire
